// >>> shared/ssrx_map.svh
`ifndef SSRX_MAP_SVH
`define SSRX_MAP_SVH

// Register indices; byte address is four times the index
`define SSRX_IDX_CH6 8'h2d
`define SSRX_IDX_CH7 8'h2e
`define SSRX_IDX_CH8 8'h2f
`define SSRX_IDX_FMT 8'h30
`define SSRX_IDX_STAT 8'h31

// Reset values
`define SSRX_RST_CH6 8'h05
`define SSRX_RST_CH7 8'h06
`define SSRX_RST_CH8 8'h07
`define SSRX_RST_FMT 8'h00

// Channel configuration fields
`define SSRX_RSVD_BIT 7
`define SSRX_SRC_MSB 6
`define SSRX_SRC_LSB 5
`define SSRX_SLOT_MSB 4
`define SSRX_SLOT_LSB 0

// Format register field
`define SSRX_FMT_MSB 1
`define SSRX_FMT_LSB 0

// Status register fields
`define SSRX_STAT_BUSY_BIT 0
`define SSRX_STAT_CNT_MSB 7
`define SSRX_STAT_CNT_LSB 1

// Destination numbering of channel 6; channels 7 and 8 follow in order
`define SSRX_PLAY_BASE 4'h6
`define SSRX_REC_BASE 4'h2
`define SSRX_LINK_BASE 4'h1

// Slot word length in link clocks
`define SSRX_WORD_BITS 32

`endif

// >>> shared/ssrx_pkg.sv
`default_nettype none
package ssrx_pkg;

  typedef enum logic [1:0] {
    SSRX_FMT_TDM,
    SSRX_FMT_I2S,
    SSRX_FMT_LJ
  } ssrx_fmt_e;

  typedef enum logic [1:0] {
    SSRX_SRC_OFF,
    SSRX_SRC_PLAY,
    SSRX_SRC_LOOP,
    SSRX_SRC_LINK
  } ssrx_src_e;

  typedef struct packed {
    ssrx_src_e src;
    logic [4:0] slot;
  } ssrx_chcfg_s;

  typedef struct packed {
    ssrx_chcfg_s [2:0] ch;
    ssrx_fmt_e fmt;
  } ssrx_cfg_s;

  typedef struct packed {
    logic valid;
    ssrx_src_e route;
    logic [3:0] target;
    logic [31:0] data;
  } ssrx_word_s;

endpackage
`default_nettype wire

// >>> rtl/ssrx_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssrx_map.svh"
// Functional notes
// RL1 - A channel 6 source field of 0 makes the block ignore the channel 6 receive word entirely.
// RL2 - A channel 6 source field of 1 delivers the channel 6 word as playback channel 6 data.
// RL3 - A channel 6 source field of 2 delivers the channel 6 word as record channel 2 loopback.
// RL4 - A channel 6 source field of 3 delivers the channel 6 word as data of linked device 1.
// RL5 - Channel 7 is disabled by source 0 and routed to playback channel 7 by source 1.
// RL6 - Channel 7 source 2 means record channel 3 loopback and source 3 means linked device 2.
// RL7 - The slot field sits in bits 4-0 and in TDM selects slot 0 to 31 of the frame.
// RL8 - In I2S or left-justified format slot values 0-15 pick left slots and 16-31 right slots 0-15.
// RL9 - The channel 6 register resets to 0x05, disabled and pointing at slot 5.
// RL10 - The channel 7 register resets to 0x06, disabled and pointing at slot 6.
// RL11 - Bit 7 of each channel register reads zero and software writes only zero into it.
// RL12 - A channel 8 register exists at index 0x2f and resets to 0x07.
// RL13 - A disabled channel ignores its slot field and forwards no word anywhere.
module ssrx_map (
  // System
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic [9:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link, all on the link clock
  input wire logic link_bclk,
  input wire logic link_fsync,
  input wire logic link_sdin,
  // Received words, channels 6 to 8
  output ssrx_pkg::ssrx_word_s [2:0] rx_word
);

  localparam logic [2:0][7:0] CFG_RST = {`SSRX_RST_CH8, `SSRX_RST_CH7, `SSRX_RST_CH6};

  logic [2:0][7:0] cfg_reg;
  logic [7:0] fmt_reg;
  logic [6:0] word_count;
  logic [7:0] idx;
  logic mapped;
  logic wr_en;
  logic [7:0] rd_byte;
  ssrx_pkg::ssrx_cfg_s live_cfg;
  ssrx_pkg::ssrx_cfg_s cfg_shadow;
  logic cfg_req;
  logic cfg_pend;
  logic cfg_busy;
  logic ack_s1, ack_s2, ack_s3, ack_seen;
  logic [2:0] acc;

  // APB decode; zero wait states while ce is high
  assign idx = paddr[9:2];
  assign pready = penable & ce;
  always_comb begin
    mapped = 1'b0;
    if (paddr[1:0] == 2'b00) begin
      case (idx)
        `SSRX_IDX_CH6, `SSRX_IDX_CH7, `SSRX_IDX_CH8, `SSRX_IDX_FMT, `SSRX_IDX_STAT: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end
  assign wr_en = psel & penable & pready & pwrite & mapped & pstrb[0];

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= CFG_RST; // RL9 RL10 RL12
      fmt_reg <= `SSRX_RST_FMT;
    end else if (ce && wr_en) begin
      case (idx)
        `SSRX_IDX_CH6: cfg_reg[0] <= {1'b0, pwdata[6:0]}; // RL11
        `SSRX_IDX_CH7: cfg_reg[1] <= {1'b0, pwdata[6:0]}; // RL11
        `SSRX_IDX_CH8: cfg_reg[2] <= {1'b0, pwdata[6:0]}; // RL11 RL12
        `SSRX_IDX_FMT: fmt_reg <= {6'h00, pwdata[1:0]};
        default: ;
      endcase
    end
  end

  // Read data is taken in the setup phase so that prdata comes from a flop
  always_comb begin
    case (idx)
      `SSRX_IDX_CH6: rd_byte = cfg_reg[0];
      `SSRX_IDX_CH7: rd_byte = cfg_reg[1];
      `SSRX_IDX_CH8: rd_byte = cfg_reg[2];
      `SSRX_IDX_FMT: rd_byte = fmt_reg;
      // A launch still pending counts as busy, so idle always means applied
      `SSRX_IDX_STAT: rd_byte = {word_count, cfg_busy | cfg_pend};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce && psel && !penable) begin
      prdata <= mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr <= !mapped;
    end
  end

  // Live configuration as the link will use it
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      live_cfg.ch[k].src = ssrx_pkg::ssrx_src_e'(cfg_reg[k][`SSRX_SRC_MSB:`SSRX_SRC_LSB]);
      live_cfg.ch[k].slot = cfg_reg[k][`SSRX_SLOT_MSB:`SSRX_SLOT_LSB]; // RL7
    end
    case (fmt_reg[`SSRX_FMT_MSB:`SSRX_FMT_LSB])
      2'h1: live_cfg.fmt = ssrx_pkg::SSRX_FMT_I2S;
      2'h2: live_cfg.fmt = ssrx_pkg::SSRX_FMT_LJ;
      default: live_cfg.fmt = ssrx_pkg::SSRX_FMT_TDM;
    endcase
  end

  // Hand configuration to the link by toggle handshake; shadow is frozen while busy
  assign cfg_busy = cfg_req != ack_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_shadow <= {CFG_RST[2][6:0], CFG_RST[1][6:0], CFG_RST[0][6:0], ssrx_pkg::SSRX_FMT_TDM};
      cfg_req <= 1'b0;
      cfg_pend <= 1'b0;
    end else if (ce) begin
      if (cfg_pend && !cfg_busy) begin
        cfg_shadow <= live_cfg;
        cfg_req <= ~cfg_req;
      end
      // A write in the launch cycle keeps the request pending
      if (wr_en) begin
        cfg_pend <= 1'b1;
      end else if (!cfg_busy) begin
        cfg_pend <= 1'b0;
      end
    end
  end

  logic lnk_ack;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
      ack_seen <= 1'b0;
    end else if (ce) begin
      ack_s1 <= lnk_ack;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      if (ack_s2 == ack_s3) begin
        ack_seen <= ack_s3;
      end
    end
  end

  // Link domain reset: asserted with presetn, released on the link clock
  logic l_rst_q1, l_rst_n;
  always_ff @(posedge link_bclk or negedge presetn) begin
    if (!presetn) begin
      l_rst_q1 <= 1'b0;
      l_rst_n <= 1'b0;
    end else begin
      l_rst_q1 <= 1'b1;
      l_rst_n <= l_rst_q1;
    end
  end

  ssrx_pkg::ssrx_cfg_s lnk_cfg;
  logic r_s1, r_s2, r_s3;
  always_ff @(posedge link_bclk or negedge l_rst_n) begin
    if (!l_rst_n) begin
      r_s1 <= 1'b0;
      r_s2 <= 1'b0;
      r_s3 <= 1'b0;
      lnk_ack <= 1'b0;
      lnk_cfg <= {CFG_RST[2][6:0], CFG_RST[1][6:0], CFG_RST[0][6:0], ssrx_pkg::SSRX_FMT_TDM};
    end else begin
      r_s1 <= cfg_req;
      r_s2 <= r_s1;
      r_s3 <= r_s2;
      if (r_s2 == r_s3 && r_s3 != lnk_ack) begin
        lnk_cfg <= cfg_shadow;
        lnk_ack <= r_s3;
      end
    end
  end

  // Frame tracking; I2S data lags its word clock edge by one link clock
  logic fs_q, edge_d, framed, side_right, right_now, bound, edge_now, last_bit;
  logic [9:0] bit_cnt, pos;
  logic [30:0] shift;
  logic [31:0] word;
  logic [4:0] slot_idx;
  logic is_tdm, is_i2s;
  assign is_tdm = lnk_cfg.fmt == ssrx_pkg::SSRX_FMT_TDM;
  assign is_i2s = lnk_cfg.fmt == ssrx_pkg::SSRX_FMT_I2S;

  always_comb begin
    edge_now = is_tdm ? (link_fsync & ~fs_q) : (link_fsync ^ fs_q);
    bound = is_i2s ? edge_d : edge_now;
    pos = bound ? 10'h000 : 10'(bit_cnt + 10'h001);
    right_now = side_right;
    if (bound) begin
      right_now = is_i2s ? fs_q : ~link_fsync;
    end
    last_bit = pos[4:0] == 5'(`SSRX_WORD_BITS - 1);
    word = {shift, link_sdin};
    // RL7 RL8
    slot_idx = is_tdm ? pos[9:5] : {right_now, pos[8:5]};
  end

  always_ff @(posedge link_bclk or negedge l_rst_n) begin
    if (!l_rst_n) begin
      fs_q <= 1'b0;
      edge_d <= 1'b0;
      framed <= 1'b0;
      side_right <= 1'b0;
      bit_cnt <= 10'h000;
      shift <= 31'h0000_0000;
    end else begin
      fs_q <= link_fsync;
      edge_d <= edge_now;
      bit_cnt <= pos;
      side_right <= right_now;
      shift <= word[30:0];
      if (bound) begin
        framed <= 1'b1;
      end
    end
  end

  // Per channel slot match and crossing to pclk
  logic [2:0] hit;
  logic [2:0] l_tgl;
  logic [31:0] l_data [3];
  ssrx_pkg::ssrx_src_e l_route [3];

  for (genvar i = 0; i < 3; i++) begin : g_ch
    logic tgl_q;
    logic [31:0] data_q;
    ssrx_pkg::ssrx_src_e route_q;
    logic s1, s2, s3, seen;
    ssrx_pkg::ssrx_word_s out_q;
    logic [3:0] tgt;

    // Half beyond slot 15 never matches in I2S or left-justified framing
    assign hit[i] = framed && last_bit && (is_tdm || !pos[9])
                    && lnk_cfg.ch[i].src != ssrx_pkg::SSRX_SRC_OFF // RL1 RL5 RL13
                    && slot_idx == lnk_cfg.ch[i].slot; // RL7 RL8

    always_ff @(posedge link_bclk or negedge l_rst_n) begin
      if (!l_rst_n) begin
        tgl_q <= 1'b0;
        data_q <= 32'h0000_0000;
        route_q <= ssrx_pkg::SSRX_SRC_OFF;
      end else if (hit[i]) begin
        tgl_q <= ~tgl_q;
        data_q <= word;
        route_q <= lnk_cfg.ch[i].src; // RL2 RL3 RL4 RL5 RL6
      end
    end
    assign l_tgl[i] = tgl_q;
    assign l_data[i] = data_q;
    assign l_route[i] = route_q;

    always_comb begin
      case (route_q)
        ssrx_pkg::SSRX_SRC_PLAY: tgt = 4'(`SSRX_PLAY_BASE + 4'(i)); // RL2 RL5
        ssrx_pkg::SSRX_SRC_LOOP: tgt = 4'(`SSRX_REC_BASE + 4'(i)); // RL3 RL6
        ssrx_pkg::SSRX_SRC_LINK: tgt = 4'(`SSRX_LINK_BASE + 4'(i)); // RL4 RL6
        default: tgt = 4'h0;
      endcase
    end

    // Data stays put for a whole slot, far longer than the toggle sync
    assign acc[i] = ce && s2 == s3 && s3 != seen;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        seen <= 1'b0;
        out_q <= '0;
      end else if (ce) begin
        s1 <= l_tgl[i];
        s2 <= s1;
        s3 <= s2;
        out_q.valid <= 1'b0;
        if (acc[i]) begin
          seen <= s3;
          out_q <= '{valid: 1'b1, route: l_route[i], target: tgt, data: l_data[i]};
        end
      end
    end
    assign rx_word[i] = out_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_count <= 7'h00;
    end else if (ce && acc != 3'b000) begin
      // Channels sharing a slot deliver in the same cycle; count each word
      word_count <= 7'(word_count + 7'($countones(acc)));
    end
  end

  // Checks
  property p_ch6_off;
    @(posedge link_bclk) disable iff (!l_rst_n)
      lnk_cfg.ch[0].src == ssrx_pkg::SSRX_SRC_OFF |-> !hit[0];
  endproperty
  a_ch6_off: assert property (p_ch6_off) else $error("channel 6 captured while disabled"); // RL1

  property p_ch6_play;
    @(posedge link_bclk) disable iff (!l_rst_n)
      hit[0] && lnk_cfg.ch[0].src == ssrx_pkg::SSRX_SRC_PLAY
      |=> l_route[0] == ssrx_pkg::SSRX_SRC_PLAY && l_data[0] == $past(word);
  endproperty
  a_ch6_play: assert property (p_ch6_play) else $error("channel 6 playback word not held"); // RL2

  property p_ch6_loop;
    @(posedge pclk) disable iff (!presetn)
      rx_word[0].valid && rx_word[0].route == ssrx_pkg::SSRX_SRC_LOOP |-> rx_word[0].target == 4'h2;
  endproperty
  a_ch6_loop: assert property (p_ch6_loop) else $error("channel 6 loopback target wrong"); // RL3

  property p_ch6_link;
    @(posedge pclk) disable iff (!presetn)
      rx_word[0].valid && rx_word[0].route == ssrx_pkg::SSRX_SRC_LINK |-> rx_word[0].target == 4'h1;
  endproperty
  a_ch6_link: assert property (p_ch6_link) else $error("channel 6 linked device wrong"); // RL4

  property p_ch7_play;
    @(posedge pclk) disable iff (!presetn)
      rx_word[1].valid |-> rx_word[1].route != ssrx_pkg::SSRX_SRC_OFF
      && (rx_word[1].route != ssrx_pkg::SSRX_SRC_PLAY || rx_word[1].target == 4'h7);
  endproperty
  a_ch7_play: assert property (p_ch7_play) else $error("channel 7 playback route wrong"); // RL5

  property p_ch7_other;
    @(posedge pclk) disable iff (!presetn)
      rx_word[1].valid |-> (rx_word[1].route != ssrx_pkg::SSRX_SRC_LOOP || rx_word[1].target == 4'h3)
      && (rx_word[1].route != ssrx_pkg::SSRX_SRC_LINK || rx_word[1].target == 4'h2);
  endproperty
  a_ch7_other: assert property (p_ch7_other) else $error("channel 7 target wrong"); // RL6

  property p_tdm_slot;
    @(posedge link_bclk) disable iff (!l_rst_n)
      hit[1] && is_tdm |-> pos[9:5] == lnk_cfg.ch[1].slot && pos[4:0] == 5'h1f;
  endproperty
  a_tdm_slot: assert property (p_tdm_slot) else $error("TDM capture outside its slot"); // RL7

  property p_half_slot;
    @(posedge link_bclk) disable iff (!l_rst_n)
      hit[2] && !is_tdm |-> !pos[9] && {right_now, pos[8:5]} == lnk_cfg.ch[2].slot;
  endproperty
  a_half_slot: assert property (p_half_slot) else $error("half-frame capture outside its slot"); // RL8

  property p_rst_ch6;
    @(posedge pclk) disable iff (!presetn)
      !$past(presetn) |-> cfg_reg[0] == 8'h05;
  endproperty
  a_rst_ch6: assert property (p_rst_ch6) else $error("channel 6 reset value wrong"); // RL9

  property p_rst_ch7;
    @(posedge pclk) disable iff (!presetn)
      !$past(presetn) |-> cfg_reg[1] == 8'h06 && !cfg_busy;
  endproperty
  a_rst_ch7: assert property (p_rst_ch7) else $error("channel 7 reset value wrong"); // RL10

  property p_rsvd_zero;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable && ce && !pwrite |=> prdata[7] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read as one"); // RL11

  property p_rst_ch8;
    @(posedge pclk) disable iff (!presetn)
      !$past(presetn) |-> cfg_reg[2] == 8'h07;
  endproperty
  a_rst_ch8: assert property (p_rst_ch8) else $error("channel 8 reset value wrong"); // RL12

  property p_off_silent;
    @(posedge link_bclk) disable iff (!l_rst_n)
      lnk_cfg.ch[1].src == ssrx_pkg::SSRX_SRC_OFF && lnk_cfg.ch[2].src == ssrx_pkg::SSRX_SRC_OFF
      |-> hit[2:1] == 2'b00;
  endproperty
  a_off_silent: assert property (p_off_silent) else $error("disabled channel forwarded a word"); // RL13

  property p_cov_loop;
    @(posedge pclk) disable iff (!presetn)
      rx_word[0].valid && rx_word[0].route == ssrx_pkg::SSRX_SRC_LOOP;
  endproperty
  c_cov_loop: cover property (p_cov_loop);

  property p_cov_i2s_right;
    @(posedge link_bclk) disable iff (!l_rst_n)
      hit[1] && is_i2s && right_now;
  endproperty
  c_cov_i2s_right: cover property (p_cov_i2s_right);

  property p_cov_handoff;
    @(posedge pclk) disable iff (!presetn)
      cfg_busy ##1 !cfg_busy;
  endproperty
  c_cov_handoff: cover property (p_cov_handoff);

endmodule // ssrx_map
`default_nettype wire

// >>> dv/ssrx_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssrx_link_model (
  // Serial link toward the block
  output logic link_bclk,
  output logic link_fsync,
  output logic link_sdin
);
  initial begin
    link_bclk = 1'b0;
    link_fsync = 1'b0;
    link_sdin = 1'b0;
  end
  // Sync and data change while the bit clock is low
  task automatic tick(input logic fs, input logic sd);
    link_fsync = fs;
    link_sdin = sd;
    #15 link_bclk = 1'b1;
    #15 link_bclk = 1'b0;
  endtask
  // Clock runs only inside these calls, otherwise it stands still
  task automatic idle(input int n, input logic [1:0] fmt);
    #7;
    repeat (n) tick(fmt == 2'h1, ~link_sdin);
  endtask
  // Left half holds words 0-15, right half words 16-31
  task automatic send_frame(input logic [1:0] fmt, input logic [31:0] w [32]);
    logic fs;
    #7;
    if (fmt == 2'h1) tick(1'b0, ~link_sdin);
    for (int k = 0; k < 1024; k++) begin
      case (fmt)
        2'h1: fs = (k >= 511);
        2'h2: fs = (k < 512);
        default: fs = (k == 0);
      endcase
      tick(fs, w[k / 32][31 - k % 32]);
    end
    // Released line shows the inverse of the last bit
    link_sdin = ~link_sdin;
  endtask
endmodule // ssrx_link_model
`default_nettype wire

// >>> dv/ssrx_map_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssrx_map.svh"
module ssrx_map_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic [9:0] paddr = 10'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wire logic link_bclk;
  wire logic link_fsync;
  wire logic link_sdin;
  ssrx_pkg::ssrx_word_s [2:0] rx_word;
  ssrx_pkg::ssrx_word_s got_q [3][$];
  int num_errors = 0;
  int tests_run = 0;
  int seed = 32'hd6ae;
  logic [31:0] rd;
  logic err;

  always #5 pclk = ~pclk;

  ssrx_map i_ssrx_map (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_bclk(link_bclk), .link_fsync(link_fsync),
    .link_sdin(link_sdin), .rx_word(rx_word));
  ssrx_link_model i_ssrx_link_model (.link_bclk(link_bclk), .link_fsync(link_fsync),
    .link_sdin(link_sdin));

  always @(posedge pclk) begin
    for (int i = 0; i < 3; i++) begin
      if (rx_word[i].valid === 1'b1) got_q[i].push_back(rx_word[i]);
    end
  end

  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_word(input ssrx_pkg::ssrx_word_s got, input ssrx_pkg::ssrx_word_s exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered right after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic wr, input logic [9:0] addr, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits as long as the slave stretches; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic ssrx_pkg::ssrx_word_s exp_word(input int ch, input logic [1:0] src,
                                                    input logic [31:0] d);
    logic [3:0] base;
    case (src)
      2'h1: base = `SSRX_PLAY_BASE;
      2'h2: base = `SSRX_REC_BASE;
      default: base = `SSRX_LINK_BASE;
    endcase
    return '{valid: 1'b1, route: ssrx_pkg::ssrx_src_e'(src), target: base + 4'(ch), data: d};
  endfunction

  initial begin
    #600000;
    num_errors++;
    end_sim();
  end

  initial begin
    logic [31:0] w [32];
    logic [1:0] src [3];
    logic [4:0] slot [3];
    logic [1:0] fmt;
    logic [9:0] a;
    int n;
    // Link reset needs several bit clocks while held
    fork
      i_ssrx_link_model.idle(6, 2'h0);
      repeat (5) @(posedge pclk);
    join
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, {`SSRX_IDX_CH6, 2'b00}, 32'h0);
    cmp_val(rd, 32'h05);
    apb(1'b0, {`SSRX_IDX_CH7, 2'b00}, 32'h0);
    cmp_val(rd, 32'h06);
    apb(1'b0, {`SSRX_IDX_CH8, 2'b00}, 32'h0);
    cmp_val(rd, 32'h07);
    apb(1'b1, {`SSRX_IDX_CH6, 2'b00}, 32'h0000_ff7f);
    apb(1'b0, {`SSRX_IDX_CH6, 2'b00}, 32'h0);
    cmp_val(rd, 32'h7f);
    apb(1'b0, 10'h3fc, 32'h0);
    cmp_val({31'h0, err}, 32'h1);
    // Last pass uses format code 3, which must behave as TDM
    for (int it = 0; it < 13; it++) begin
      fmt = 2'(it / 4);
      apb(1'b1, {`SSRX_IDX_FMT, 2'b00}, {30'h0, fmt});
      for (int c = 0; c < 3; c++) begin
        src[c] = 2'(it + c);
        // Field edges first, random slots after
        if (it % 4 == 0) slot[c] = (c == 0) ? 5'd0 : (c == 1 ? 5'd31 : 5'd16);
        else if (it % 4 == 1) slot[c] = 5'd15;
        else slot[c] = 5'($random(seed));
        a = {8'(`SSRX_IDX_CH6 + c), 2'b00};
        apb(1'b1, a, {25'h0, src[c], slot[c]});
        apb(1'b0, a, 32'h0);
        cmp_val(rd, {25'h0, src[c], slot[c]});
      end
      // Config handoff needs the bit clock running
      n = 0;
      do begin
        i_ssrx_link_model.idle(16, fmt);
        // Idle clocks may complete a stray slot; let it land before the queues are cleared
        repeat (10) @(posedge pclk);
        apb(1'b0, {`SSRX_IDX_STAT, 2'b00}, 32'h0);
        n++;
      end while (rd[0] !== 1'b0 && n < 10);
      cmp_val({31'h0, rd[0]}, 32'h0);
      for (int k = 0; k < 32; k++) w[k] = $random(seed);
      for (int c = 0; c < 3; c++) got_q[c].delete();
      i_ssrx_link_model.send_frame(fmt, w);
      // Words land a few pclk after their last bit
      repeat (30) @(posedge pclk);
      for (int c = 0; c < 3; c++) begin
        cmp_val(got_q[c].size(), 32'(src[c] != 2'h0));
        if (src[c] != 2'h0 && got_q[c].size() == 1)
          cmp_word(got_q[c][0], exp_word(c, src[c], w[slot[c]]));
      end
    end
    end_sim();
  end
endmodule // ssrx_map_bench
`default_nettype wire
